/* File: shared/lvdc_pkg.sv */
// ----------------------------------------
// Low-voltage detector control constants
// ----------------------------------------
package lvdc_pkg;
   // Register byte offsets
   localparam logic [3:0] LVDC_OFF_CTRL = 4'h0;
   localparam logic [3:0] LVDC_OFF_STATUS = 4'h4;
   localparam logic [3:0] LVDC_OFF_MASK = 4'h8;
   // Control field positions
   localparam int LVDC_CTRL_LEVEL_LSB = 0;
   localparam int LVDC_CTRL_LEVEL_W = 4;
   localparam int LVDC_CTRL_EN_BIT = 4;
   localparam int LVDC_CTRL_STABLE_BIT = 5;
   // Status and mask field positions
   localparam int LVDC_ST_LOWV_BIT = 0;
   localparam int LVDC_ST_STABLE_BIT = 1;
   localparam int LVDC_ST_W = 2;
   // Reset values and the external level code
   localparam logic [3:0] LVDC_LEVEL_RESET = 4'h5;
   localparam logic [3:0] LVDC_LEVEL_EXTERNAL = 4'hF;
   localparam logic LVDC_EN_RESET = 1'b0;
   localparam logic [LVDC_ST_W-1:0] LVDC_MASK_RESET = 2'h0;
   // AXI responses
   localparam logic [1:0] LVDC_RESP_OKAY = 2'h0;
   localparam logic [1:0] LVDC_RESP_SLVERR = 2'h2;
   // Reference settling time, converted to cycles of a 4 ns clock
   localparam int LVDC_CLK_PERIOD_PS = 4000;
   localparam int LVDC_SETTLE_TIME_US = 50;
   localparam int LVDC_SETTLE_CYCLES =
      (LVDC_SETTLE_TIME_US * 1000000 + LVDC_CLK_PERIOD_PS - 1) / LVDC_CLK_PERIOD_PS;
endpackage

/* File: src/lvdc_settle_timer.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Reference settling timer
// ----------------------------------------
module lvdc_settle_timer
   import lvdc_pkg::*;
#(
   parameter int SETTLE_CYCLES = LVDC_SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Control
   input wire logic enable,
   input wire logic refAlreadyRunning,
   // Result
   output logic stable
);
   localparam int CW = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES - 1);

   logic [CW-1:0] count_reg; // Elapsed settle cycles
   logic [CW-1:0] count_next;
   logic stable_reg; // Reference settled
   logic stable_next;

   // Next-state: count while enabled, clear on disable
   always_comb begin
      count_next = count_reg;
      stable_next = stable_reg;
      if (!enable) begin
         // Power-down forces a fresh wait
         count_next = '0;
         stable_next = 1'b0;
      end else if (!stable_reg) begin
         if (refAlreadyRunning || count_reg == LAST) begin
            // Shared reference skips the wait; otherwise the last count sets stable
            stable_next = 1'b1;
         end else begin
            count_next = count_reg + 1'b1;
         end
      end
   end

   // Register stage
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= '0;
         stable_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         stable_reg <= stable_next;
      end
   end

   assign stable = stable_reg;
endmodule

/* File: src/lvdc_top.sv */
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module lvdc_top
   import lvdc_pkg::*;
#(
   parameter int SETTLE_CYCLES = LVDC_SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // AXI4-Lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog front end
   input wire logic belowReference,
   input wire logic refAlreadyRunning,
   output logic detectorPowerEn,
   output logic [3:0] tripLevelSelect,
   output logic externalTripSelect,
   // Core power and interrupt
   input wire logic coreSleeping,
   input wire logic globalIntEnable,
   output logic wakeRequest,
   output logic resumeAtVector,
   output logic irq
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic awHeld_reg; // Write address captured
   logic awHeld_next;
   logic [3:0] awAddr_reg;
   logic [3:0] awAddr_next;
   logic wHeld_reg; // Write data captured
   logic wHeld_next;
   logic [31:0] wData_reg;
   logic [31:0] wData_next;
   logic [3:0] wStrb_reg;
   logic [3:0] wStrb_next;
   logic bValid_reg;
   logic bValid_next;
   logic [1:0] bResp_reg;
   logic [1:0] bResp_next;
   logic rValid_reg;
   logic rValid_next;
   logic [31:0] rData_reg;
   logic [31:0] rData_next;
   logic [1:0] rResp_reg;
   logic [1:0] rResp_next;
   logic [3:0] level_reg; // Trip level field
   logic [3:0] level_next;
   logic enable_reg; // Detector enable
   logic enable_next;
   logic [LVDC_ST_W-1:0] status_reg; // Sticky events
   logic [LVDC_ST_W-1:0] status_next;
   logic [LVDC_ST_W-1:0] mask_reg; // Interrupt mask
   logic [LVDC_ST_W-1:0] mask_next;
   logic extSel_reg;
   logic extSel_next;
   logic stablePrev_reg; // For stable rising edge
   logic wake_reg;
   logic wake_next;
   logic vector_reg;
   logic vector_next;
   logic irq_reg;
   logic irq_next;
   logic awReady_reg; // Address slot free
   logic wReady_reg; // Data slot free
   logic arReady_reg; // No read answer pending
   logic refStable; // From settle timer
   logic lowEvent; // Qualified detection
   logic doWrite; // Both write halves held
   logic [LVDC_ST_W-1:0] setBits;
   logic [LVDC_ST_W-1:0] clrBits;

   // ----------------------------------------
   // Settling timer
   // ----------------------------------------
   // Fixed-time count, bypassed if reference shared
   lvdc_settle_timer #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_settle (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .enable(enable_reg),
      .refAlreadyRunning(refAlreadyRunning),
      .stable(refStable)
   );

   // ----------------------------------------
   // Detection
   // ----------------------------------------
   // Flag only from a powered, settled comparator
   assign lowEvent = enable_reg && refStable && belowReference;
   assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
   assign setBits = {refStable && !stablePrev_reg, lowEvent};

   // ----------------------------------------
   // AXI write path and registers
   // ----------------------------------------
   // Next values for write channel and writable registers
   always_comb begin
      awHeld_next = awHeld_reg;
      awAddr_next = awAddr_reg;
      wHeld_next = wHeld_reg;
      wData_next = wData_reg;
      wStrb_next = wStrb_reg;
      bValid_next = bValid_reg;
      bResp_next = bResp_reg;
      level_next = level_reg;
      enable_next = enable_reg;
      mask_next = mask_reg;
      clrBits = '0;
      // Take address and data in either order
      if (s_axi_awvalid && !awHeld_reg) begin
         awHeld_next = 1'b1;
         awAddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_reg) begin
         wHeld_next = 1'b1;
         wData_next = s_axi_wdata;
         wStrb_next = s_axi_wstrb;
      end
      // Commit once both halves are in
      if (doWrite) begin
         awHeld_next = 1'b0;
         wHeld_next = 1'b0;
         bValid_next = 1'b1;
         bResp_next = LVDC_RESP_OKAY;
         unique case ({awAddr_reg[3:2], 2'b00})
            LVDC_OFF_CTRL: begin
               // Bits 7-6 and stable bit ignore writes
               if (wStrb_reg[0]) begin
                  level_next = wData_reg[LVDC_CTRL_LEVEL_LSB +: LVDC_CTRL_LEVEL_W];
                  enable_next = wData_reg[LVDC_CTRL_EN_BIT];
               end
            end
            LVDC_OFF_STATUS: begin
               // Write one to clear
               if (wStrb_reg[0]) begin
                  clrBits = wData_reg[LVDC_ST_W-1:0];
               end
            end
            LVDC_OFF_MASK: begin
               if (wStrb_reg[0]) begin
                  mask_next = wData_reg[LVDC_ST_W-1:0];
               end
            end
            default: begin
               // Unmapped address
               bResp_next = LVDC_RESP_SLVERR;
            end
         endcase
      end
      // Response retires on handshake
      if (bValid_reg && s_axi_bready) begin
         bValid_next = 1'b0;
      end
   end

   // ----------------------------------------
   // Status, interrupt and wake
   // ----------------------------------------
   // Set wins over a same-cycle clear
   always_comb begin
      status_next = (status_reg & ~clrBits) | setBits;
      // Mux select follows the programmed level
      extSel_next = (level_next == LVDC_LEVEL_EXTERNAL);
      irq_next = |(status_next & mask_next);
      // Sleep wake on detection
      wake_next = coreSleeping && lowEvent;
      // Vector only with both enables
      vector_next = coreSleeping && lowEvent && globalIntEnable
         && mask_next[LVDC_ST_LOWV_BIT];
   end

   // ----------------------------------------
   // AXI read path
   // ----------------------------------------
   // Read data one cycle after address
   always_comb begin
      rValid_next = rValid_reg;
      rData_next = rData_reg;
      rResp_next = rResp_reg;
      if (rValid_reg && s_axi_rready) begin
         rValid_next = 1'b0;
      end
      if (s_axi_arvalid && !rValid_reg) begin
         rValid_next = 1'b1;
         rData_next = '0;
         rResp_next = LVDC_RESP_OKAY;
         unique case ({s_axi_araddr[3:2], 2'b00})
            LVDC_OFF_CTRL: begin
               // Upper bits stay zero
               rData_next[LVDC_CTRL_LEVEL_LSB +: LVDC_CTRL_LEVEL_W] = level_reg;
               rData_next[LVDC_CTRL_EN_BIT] = enable_reg;
               rData_next[LVDC_CTRL_STABLE_BIT] = refStable;
            end
            LVDC_OFF_STATUS: begin
               rData_next[LVDC_ST_W-1:0] = status_reg;
            end
            LVDC_OFF_MASK: begin
               rData_next[LVDC_ST_W-1:0] = mask_reg;
            end
            default: begin
               rResp_next = LVDC_RESP_SLVERR;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Register stage
   // ----------------------------------------
   // Any reset returns control to disabled
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         awHeld_reg <= 1'b0;
         awAddr_reg <= 4'h0;
         wHeld_reg <= 1'b0;
         wData_reg <= 32'h0;
         wStrb_reg <= 4'h0;
         bValid_reg <= 1'b0;
         bResp_reg <= LVDC_RESP_OKAY;
         rValid_reg <= 1'b0;
         rData_reg <= 32'h0;
         rResp_reg <= LVDC_RESP_OKAY;
         level_reg <= LVDC_LEVEL_RESET;
         enable_reg <= LVDC_EN_RESET;
         status_reg <= '0;
         mask_reg <= LVDC_MASK_RESET;
         extSel_reg <= 1'b0;
         stablePrev_reg <= 1'b0;
         wake_reg <= 1'b0;
         vector_reg <= 1'b0;
         irq_reg <= 1'b0;
         awReady_reg <= 1'b1;
         wReady_reg <= 1'b1;
         arReady_reg <= 1'b1;
      end else begin
         awHeld_reg <= awHeld_next;
         awAddr_reg <= awAddr_next;
         wHeld_reg <= wHeld_next;
         wData_reg <= wData_next;
         wStrb_reg <= wStrb_next;
         bValid_reg <= bValid_next;
         bResp_reg <= bResp_next;
         rValid_reg <= rValid_next;
         rData_reg <= rData_next;
         rResp_reg <= rResp_next;
         level_reg <= level_next;
         enable_reg <= enable_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         extSel_reg <= extSel_next;
         stablePrev_reg <= refStable;
         wake_reg <= wake_next;
         vector_reg <= vector_next;
         irq_reg <= irq_next;
         awReady_reg <= !awHeld_next;
         wReady_reg <= !wHeld_next;
         arReady_reg <= !rValid_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_awready = awReady_reg;
   assign s_axi_wready = wReady_reg;
   assign s_axi_bvalid = bValid_reg;
   assign s_axi_bresp = bResp_reg;
   assign s_axi_arready = arReady_reg;
   assign s_axi_rvalid = rValid_reg;
   assign s_axi_rdata = rData_reg;
   assign s_axi_rresp = rResp_reg;
   // Power follows enable alone
   assign detectorPowerEn = enable_reg;
   assign tripLevelSelect = level_reg;
   assign externalTripSelect = extSel_reg;
   assign wakeRequest = wake_reg;
   assign resumeAtVector = vector_reg;
   assign irq = irq_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   a_flag_needs_stable: assert property (
      $rose(status_reg[LVDC_ST_LOWV_BIT]) |-> $past(refStable) && $past(enable_reg))
      else $error("Low-voltage flag set before reference stable");
   a_upper_bits_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
      else $error("Unimplemented control bits read nonzero");
   a_disable_clears_stable: assert property (
      !enable_reg |=> !refStable)
      else $error("Stable flag survived disable");
   a_shared_ref_fast: assert property (
      $rose(enable_reg) && refAlreadyRunning |=> refStable)
      else $error("Shared reference still waited");
   a_settle_not_early: assert property (
      $rose(enable_reg) && !refAlreadyRunning ##1 !refAlreadyRunning |-> !refStable)
      else $error("Stable flag rose too early");
   a_ext_select: assert property (
      externalTripSelect == (tripLevelSelect == LVDC_LEVEL_EXTERNAL))
      else $error("External select does not track level");
   a_power_follows_en: assert property (
      $rose(detectorPowerEn) |-> $past(doWrite))
      else $error("Power rose without a write");
   a_sleep_wake: assert property (
      coreSleeping && lowEvent |=> wakeRequest && status_reg[LVDC_ST_LOWV_BIT])
      else $error("No wake on low-voltage in sleep");
   a_vector_gated: assert property (
      resumeAtVector |-> wakeRequest && $past(globalIntEnable))
      else $error("Vector without global enable");
   a_irq_level: assert property (
      ##1 irq == |(status_reg & mask_reg))
      else $error("Interrupt does not match status and mask");

   c_stable_reached: cover property ($rose(refStable));
   c_low_event: cover property ($rose(status_reg[LVDC_ST_LOWV_BIT]) && irq_next);
   c_sleep_wake: cover property (wakeRequest && resumeAtVector);
   c_ext_input: cover property (externalTripSelect && lowEvent);
endmodule

/* File: verification/lvdc_tb.sv */
`timescale 1ns/1ps
module lvdc_tb import lvdc_pkg::*; ;
   // ----------------------------------------
   // Bench signals
   // ----------------------------------------
   localparam int SETTLE = 16; // Short settling count for simulation
   logic core_clk = 1'b0; // System clock
   logic reset_n = 1'b0; // Async reset
   logic [3:0] awAddr = 4'h0, arAddr = 4'h0, wStrb = 4'hF;
   logic [31:0] wData = 32'h0;
   logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic awReady, wReady, bValid, arReady, rValid;
   logic [1:0] bResp, rResp;
   logic [31:0] rData;
   logic below = 1'b0, refRun = 1'b0, sleeping = 1'b0, globalEn = 1'b0; // Analog and core side
   logic powerEn, extSel, wake, atVector, irq;
   logic [3:0] level;
   int nErrors = 0, cmpCount = 0, cyc = 0, t0, k;
   logic [31:0] seed = 32'h999A8699; // Random source state
   logic [31:0] rd; // Last read data
   logic [1:0] rsp; // Last response
   int mLevel = 5, mEn = 0; // Model of the control register
`define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin nErrors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

   // ----------------------------------------
   // Clock, cycle count and design
   // ----------------------------------------
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   lvdc_top #(.SETTLE_CYCLES(SETTLE)) dut (.core_clk(core_clk), .reset_n(reset_n),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .belowReference(below), .refAlreadyRunning(refRun), .detectorPowerEn(powerEn),
      .tripLevelSelect(level), .externalTripSelect(extSel), .coreSleeping(sleeping),
      .globalIntEnable(globalEn), .wakeRequest(wake), .resumeAtVector(atVector), .irq(irq));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Next random word
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected control word from the model
   function automatic logic [31:0] ctrlExp(input int st);
      return 32'(mLevel + 16 * mEn + 32 * st);
   endfunction
   // Bus write, address and data offered together
   task automatic axWrite(input logic [3:0] a, input logic [31:0] d);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awReady) awValid <= 1'b0;
         if (wReady) wValid <= 1'b0;
      end while (bValid !== 1'b1);
      rsp = bResp;
      bReady <= 1'b0;
      @(posedge core_clk);
   endtask
   // Bus read
   task automatic axRead(input logic [3:0] a);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arReady) arValid <= 1'b0;
      end while (rValid !== 1'b1);
      rd = rData;
      rsp = rResp;
      rReady <= 1'b0;
      @(posedge core_clk);
   endtask
   // Read and compare data and response
   task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
      axRead(a);
      `CHK(rd, e)
      `CHK(rsp, LVDC_RESP_OKAY)
   endtask
   // Counts and verdict
   task automatic endOfTest();
      $display("Counts: compares=%0d mismatches=%0d", cmpCount, nErrors);
      if (nErrors == 0 && cmpCount > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   initial begin
      repeat (5000) @(posedge core_clk);
      nErrors++;
      $display("Watchdog expired at %0t", $time);
      endOfTest();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      // Reset state
      rdChk(LVDC_OFF_CTRL, ctrlExp(0));
      `CHK(level, 4'h5)
      `CHK(powerEn, 1'b0)
      rdChk(LVDC_OFF_STATUS, 32'h0);
      rdChk(LVDC_OFF_MASK, 32'h0);
      $display("Reset test done");
      // All sixteen levels, random upper bits, detector off
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         mLevel = i;
         axWrite(LVDC_OFF_CTRL, {seed[31:5], 1'b0, i[3:0]});
         rdChk(LVDC_OFF_CTRL, ctrlExp(0));
         `CHK(level, i[3:0])
         `CHK(extSel, i == 15)
      end
      $display("Level test done");
      // Unmapped place
      axWrite(4'hC, 32'hFFFFFFFF);
      `CHK(rsp, LVDC_RESP_SLVERR)
      axRead(4'hC);
      `CHK(rsp, LVDC_RESP_SLVERR)
      `CHK(rd, 32'h0)
      // Lane 0 strobe low: write ignored but answered
      wStrb <= 4'hE;
      axWrite(LVDC_OFF_CTRL, 32'h0);
      wStrb <= 4'hF;
      `CHK(rsp, LVDC_RESP_OKAY)
      rdChk(LVDC_OFF_CTRL, ctrlExp(0));
      $display("Unmapped test done");
      // Enable with supply already low: flag held off until stable
      mLevel = 3;
      mEn = 1;
      below <= 1'b1;
      axWrite(LVDC_OFF_CTRL, 32'h3);
      rdChk(LVDC_OFF_MASK, 32'h0);
      axWrite(LVDC_OFF_CTRL, 32'hF3);
      t0 = cyc;
      rdChk(LVDC_OFF_STATUS, 32'h0);
      rdChk(LVDC_OFF_CTRL, ctrlExp(0));
      `CHK(powerEn, 1'b1)
      k = 0;
      do begin
         axRead(LVDC_OFF_CTRL);
         k++;
      end while (rd[5] !== 1'b1 && k < 20);
      `CHK(rd, ctrlExp(1))
      `CHK(cyc - t0 >= SETTLE - 1, 1'b1)
      rdChk(LVDC_OFF_STATUS, 32'h3);
      below <= 1'b0;
      axWrite(LVDC_OFF_STATUS, 32'h3);
      rdChk(LVDC_OFF_STATUS, 32'h0);
      $display("Settle test done");
      // Unmasked detection raises the interrupt while awake
      axWrite(LVDC_OFF_MASK, 32'h1);
      rdChk(LVDC_OFF_MASK, 32'h1);
      below <= 1'b1;
      repeat (3) @(posedge core_clk);
      `CHK(irq, 1'b1)
      `CHK(wake, 1'b0)
      below <= 1'b0;
      axWrite(LVDC_OFF_STATUS, 32'h1);
      `CHK(irq, 1'b0)
      $display("Interrupt test done");
      // Detection in sleep, with and without global enable
      for (int g = 0; g < 2; g++) begin
         sleeping <= 1'b1;
         globalEn <= g[0];
         below <= 1'b1;
         repeat (3) @(posedge core_clk);
         `CHK(wake, 1'b1)
         `CHK(atVector, g[0])
         below <= 1'b0;
         sleeping <= 1'b0;
         axWrite(LVDC_OFF_STATUS, 32'h1);
      end
      $display("Sleep test done");
      // Disable drops power, stable flag and detection
      mEn = 0;
      axWrite(LVDC_OFF_CTRL, 32'(mLevel));
      rdChk(LVDC_OFF_CTRL, ctrlExp(0));
      `CHK(powerEn, 1'b0)
      below <= 1'b1;
      repeat (3) @(posedge core_clk);
      below <= 1'b0;
      rdChk(LVDC_OFF_STATUS, 32'h0);
      $display("Disable test done");
      // Shared reference already on: no long wait
      refRun <= 1'b1;
      mEn = 1;
      axWrite(LVDC_OFF_CTRL, 32'(16 + mLevel));
      rdChk(LVDC_OFF_CTRL, ctrlExp(1));
      refRun <= 1'b0;
      $display("Shared reference test done");
      // Reset in mid-run
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      mLevel = 5;
      mEn = 0;
      rdChk(LVDC_OFF_CTRL, ctrlExp(0));
      rdChk(LVDC_OFF_MASK, 32'h0);
      `CHK(powerEn, 1'b0)
      $display("Second reset test done");
      endOfTest();
   end
endmodule
